// ### logic/i2c_bit_level_port.sv
// bit-level i2c port: two registers, pin logic, receive bit buffer
`timescale 1ns/1ps
module i2c_bit_level_port
    import i2c_bit_port_pkg::*;
#(
    parameter int               BUF_W    = 1,
    parameter int               BUF_D    = 2,
    parameter logic [CNT_W-1:0] HALF_CYC = CNT_W'(SCL_HALF_CYC)
) (
    // clock, reset, enable
    input  wire logic             ref_clk,
    input  wire logic             resetn,
    input  wire logic             clk_en,
    // register port
    input  wire logic [7:0]       addr,
    input  wire logic [7:0]       wdata,
    input  wire logic             wr,
    input  wire logic             rd,
    output logic      [7:0]       rdata,
    // i2c pins, open drain
    input  wire logic             scl_in,
    output logic                  scl_out,
    output logic                  scl_oe,
    input  wire logic             sda_in,
    output logic                  sda_out,
    output logic                  sda_oe,
    // received bit stream
    output logic                  rx_valid,
    output logic      [BUF_W-1:0] rx_bit,
    input  wire logic             rx_ready
);

    localparam int PW = (BUF_D > 1) ? $clog2(BUF_D) : 1;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
        ptr_inc = (p == PW'(BUF_D - 1)) ? '0 : PW'(p + 1'b1);
    endfunction

    reg_req_t         req;
    logic             scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
    flags_t           flags_r, flags_nxt, flag_set, flag_clr;
    logic             received_bit_r, xbit_r, tx_act_r, tx_act_nxt;
    logic             ign_r, ign_nxt, master_r, master_nxt;
    logic             scl_low_r, scl_low_nxt, sda_low_r, sda_low_nxt;
    logic             gen_stop_r, gen_stop_nxt;
    gen_st_t          gen_r, gen_nxt;
    logic             fsm_load;
    logic [CNT_W-1:0] cnt_r, cnt_nxt;
    logic [7:0]       rdata_r, rdata_nxt;
    logic [BUF_W-1:0] buf_r [BUF_D];
    logic [PW-1:0]    wp_r, rp_r;
    logic [PW:0]      cnt_buf_r;

    // bus decode
    assign req    = '{wr: wr, rd: rd, addr: addr, wdata: wdata};
    wire   con_wr = req.wr & hit(req.addr, OFF_CON);
    wire   dat_wr = req.wr & hit(req.addr, OFF_DAT);
    wire   con_rd = req.rd & hit(req.addr, OFF_CON);
    wire   dat_rd = req.rd & hit(req.addr, OFF_DAT);

    // bus events seen through the synchronisers
    wire scl_rise  = scl_s & ~scl_d;
    wire start_det = scl_s & scl_d & sda_d & ~sda_s;
    wire stop_det  = scl_s & scl_d & ~sda_d & sda_s;
    wire watching  = master_r | ~ign_r;
    wire gen_idle  = (gen_r == GEN_IDLE);
    wire cnt_zero  = (cnt_r == '0);

    // receive buffer handshake
    wire buf_full  = (cnt_buf_r == (PW+1)'(BUF_D));
    wire buf_in_rdy = ~buf_full;
    wire buf_push  = flag_set.bit_ready_flag & buf_in_rdy;
    wire buf_pop   = rx_valid & rx_ready;

    // any pending flag or a full buffer stalls the clock line
    wire hold = (|flags_r) | ~buf_in_rdy;

    // flag set terms; own start/stop generation does not raise ready
    assign flag_set.bit_ready_flag = scl_rise & ~ign_r & gen_idle;
    assign flag_set.arbitration_loss_flag  = scl_rise & tx_act_r & xbit_r & ~sda_s & gen_idle;
    assign flag_set.str  = start_det & watching;
    assign flag_set.stop_detected_flag  = stop_det & watching;

    // flag clear terms
    assign flag_clr.bit_ready_flag = dat_wr | dat_rd | (con_wr & req.wdata[CON_CDR]);
    assign flag_clr.arbitration_loss_flag  = con_wr & req.wdata[CON_CLEAR_ARBITRATION_LOSS];
    assign flag_clr.str  = con_wr & req.wdata[CON_CLEAR_START_DETECTED];
    assign flag_clr.stop_detected_flag  = con_wr & req.wdata[CON_CLEAR_STOP_DETECTED];

    // a set in the same cycle as its clear wins
    assign flags_nxt = (flags_r & ~flag_clr) | flag_set;

    // transmit-active: data write enters, data read or clear bit leaves
    assign tx_act_nxt = dat_wr ? 1'b1 :
                        (dat_rd | (con_wr & req.wdata[CON_CXA])) ? 1'b0 :
                        flag_set.arbitration_loss_flag ? 1'b0 : tx_act_r;

    // ignore the bus as slave until the next stop frees it
    assign ign_nxt = (con_wr & req.wdata[CON_IGN] & ~master_r) ? 1'b1 :
                     stop_det ? 1'b0 : ign_r;

    // start/stop generator launch
    wire gen_go   = con_wr & gen_idle &
                    (req.wdata[CON_SEND_REPEATED_START] | req.wdata[CON_SEND_STOP]);
    wire gen_done = (gen_r == GEN_EDGE) & cnt_zero;
    assign gen_stop_nxt = gen_go ? req.wdata[CON_SEND_STOP] : gen_stop_r;

    // mastership follows generated starts, stops and lost arbitration
    assign master_nxt = flag_set.arbitration_loss_flag ? 1'b0 :
                        gen_done ? ~gen_stop_r : master_r;

    // master clock phase toggles after a half period
    wire m_toggle = master_r & gen_idle & cnt_zero &
                    (scl_low_r ? ~hold : scl_s);
    wire cnt_load = fsm_load | m_toggle;
    assign cnt_nxt = cnt_load ? HALF_CYC :
                     cnt_zero ? cnt_r : CNT_W'(cnt_r - 1'b1);

    // clock line pull: generator phases first, then master clocking
    assign scl_low_nxt = gen_done ? ~gen_stop_r :
                         (gen_r == GEN_SETUP || gen_nxt == GEN_SETUP) ? 1'b1 :
                         ~gen_idle ? 1'b0 :
                         ~master_r ? 1'b0 :
                         m_toggle ? ~scl_low_r : scl_low_r;

    // data line pull changes only while the clock line is low, except at the generator data edge and the release on arbitration loss
    wire tx_drive = tx_act_r & ~flags_r.arbitration_loss_flag & ~xbit_r;
    assign sda_low_nxt = (gen_r == GEN_SETUP) ? (scl_s ? sda_low_r : gen_stop_r) :
                         (gen_r == GEN_EDGE) ? ~gen_stop_r :
                         (gen_r == GEN_SCLHI) ? sda_low_r :
                         flags_r.arbitration_loss_flag ? 1'b0 :
                         ~scl_s ? tx_drive : sda_low_r;

    // read mux: the data registers answer one cycle after the strobe
    wire [7:0] con_view = {received_bit_r, |flags_r, flags_r.bit_ready_flag, flags_r.arbitration_loss_flag,
                           flags_r.str, flags_r.stop_detected_flag, master_r, CON_RESET[0]};
    assign rdata_nxt = con_rd ? con_view :
                       dat_rd ? {received_bit_r, 7'h00} : 8'h00;

    // generator sequence: setup with clock low, clock high, data edge
    always_comb begin
        gen_nxt  = gen_r;
        fsm_load = 1'b0;
        unique case (gen_r)
            GEN_IDLE: if (gen_go) begin
                gen_nxt  = GEN_SETUP;
                fsm_load = 1'b1;
            end
            GEN_SETUP: if (cnt_zero) begin
                gen_nxt  = GEN_SCLHI;
                fsm_load = 1'b1;
            end
            GEN_SCLHI: if (cnt_zero && scl_s) begin
                gen_nxt  = GEN_EDGE;
                fsm_load = 1'b1;
            end
            GEN_EDGE: if (cnt_zero) begin
                gen_nxt  = GEN_IDLE;
                fsm_load = 1'b1;
            end
        endcase
    end

    // pin synchronisers, two flops then an edge stage
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            {scl_m, scl_s, scl_d} <= 3'h7;
            {sda_m, sda_s, sda_d} <= 3'h7;
        end else if (clk_en) begin
            {scl_m, scl_s, scl_d} <= {scl_in, scl_m, scl_s};
            {sda_m, sda_s, sda_d} <= {sda_in, sda_m, sda_s};
        end
    end

    // flags and mode state
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            flags_r  <= '0;
            tx_act_r <= 1'b0;
            ign_r    <= 1'b0;
            master_r <= 1'b0;
        end else if (clk_en) begin
            flags_r  <= flags_nxt;
            tx_act_r <= tx_act_nxt;
            ign_r    <= ign_nxt;
            master_r <= master_nxt;
        end
    end

    // received and transmitted bit
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            received_bit_r <= CON_RESET[DAT_BIT];
            xbit_r <= 1'b1;
        end else if (clk_en) begin
            if (scl_rise) received_bit_r <= sda_s;
            if (dat_wr) xbit_r <= req.wdata[DAT_BIT];
        end
    end

    // generator, timer and pin drivers
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            gen_r      <= GEN_IDLE;
            gen_stop_r <= 1'b0;
            cnt_r      <= '0;
            scl_low_r  <= 1'b0;
            sda_low_r  <= 1'b0;
            rdata_r    <= 8'h00;
        end else if (clk_en) begin
            gen_r      <= gen_nxt;
            gen_stop_r <= gen_stop_nxt;
            cnt_r      <= cnt_nxt;
            scl_low_r  <= scl_low_nxt;
            sda_low_r  <= sda_low_nxt;
            rdata_r    <= rdata_nxt;
        end
    end

    // receive buffer: a stall downstream fills it and then holds scl
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            wp_r      <= '0;
            rp_r      <= '0;
            cnt_buf_r <= '0;
        end else if (clk_en) begin
            if (buf_push) begin
                buf_r[wp_r] <= BUF_W'(sda_s);
                wp_r        <= ptr_inc(wp_r);
            end
            if (buf_pop) rp_r <= ptr_inc(rp_r);
            cnt_buf_r <= cnt_buf_r + (PW+1)'(buf_push) - (PW+1)'(buf_pop);
        end
    end

    // slaves stretch the low phase while anything is pending
    wire slave_hold = ~master_r & gen_idle & hold & ~scl_s;

    // outputs
    assign scl_out  = 1'b0;
    assign sda_out  = 1'b0;
    assign scl_oe   = scl_low_r | slave_hold;
    assign sda_oe   = sda_low_r;
    assign rdata    = rdata_r;
    assign rx_valid = (cnt_buf_r != '0);
    assign rx_bit   = buf_r[rp_r];

    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    a_received_bit_capture: assert property (scl_rise && clk_en |=> received_bit_r == $past(sda_s))
        else $error("received bit not captured on scl rise");

    a_read_clears: assert property (dat_rd && clk_en && !flag_set.bit_ready_flag |=>
        !flags_r.bit_ready_flag && !tx_act_r)
        else $error("data read left ready or transmit active");

    a_write_loads: assert property (dat_wr && clk_en |=>
        xbit_r == $past(req.wdata[DAT_BIT]))
        else $error("data write did not load transmit bit");

    a_write_enters: assert property (dat_wr && clk_en && !flag_set.bit_ready_flag |=>
        tx_act_r && !flags_r.bit_ready_flag)
        else $error("data write did not enter transmit");

    a_ignore_set: assert property (con_wr && req.wdata[CON_IGN] && !master_r
        && clk_en |=> ign_r)
        else $error("ignore request not taken");

    a_rstart_gen: assert property (gen_go && !req.wdata[CON_SEND_STOP] && clk_en
        |=> gen_r == GEN_SETUP ##1 gen_r == GEN_SETUP)
        else $error("repeated start not launched");

    a_hold_scl: assert property ((flags_r.arbitration_loss_flag || flags_r.str || flags_r.stop_detected_flag)
        && !master_r && gen_idle && !scl_s |-> scl_oe)
        else $error("clock released while a flag is pending");

    a_atn_view: assert property (con_rd && clk_en |=>
        rdata[CON_ATN] == $past(|flags_r))
        else $error("attention does not match flags");

    a_bit_ready_flag_set: assert property (flag_set.bit_ready_flag && clk_en |=> flags_r.bit_ready_flag)
        else $error("ready flag not set on scl rise");

    a_stop_clear: assert property (flag_clr.stop_detected_flag && !flag_set.stop_detected_flag && clk_en
        |=> !flags_r.stop_detected_flag)
        else $error("stop flag not cleared");

    a_rdata_once: assert property (!req.rd && clk_en |=> rdata == 8'h00)
        else $error("read data stands outside its cycle");

    a_dat_view: assert property (dat_rd && clk_en |=>
        rdata == {$past(received_bit_r), 7'h00})
        else $error("data read does not show received bit");

    a_ignore_bus: assert property (ign_r && !master_r |->
        !flag_set.bit_ready_flag && !flag_set.str && !flag_set.stop_detected_flag)
        else $error("ignored bus still raised a flag");

    a_full_hold: assert property (buf_full && !master_r && gen_idle && !scl_s
        |-> scl_oe)
        else $error("clock released while the buffer is full");

    a_arl_set: assert property (flag_set.arbitration_loss_flag && !dat_wr && clk_en |=>
        flags_r.arbitration_loss_flag && !tx_act_r && !master_r)
        else $error("arbitration loss not taken");

    a_arl_release: assert property (flags_r.arbitration_loss_flag && gen_idle && clk_en |=> !sda_oe)
        else $error("data line still pulled after arbitration loss");

    a_start_set: assert property (flag_set.str && clk_en |=> flags_r.str)
        else $error("start flag not set");

    a_stop_set: assert property (flag_set.stop_detected_flag && clk_en |=> flags_r.stop_detected_flag)
        else $error("stop flag not set");

    a_ready_clear: assert property (flag_clr.bit_ready_flag && !flag_set.bit_ready_flag && clk_en
        |=> !flags_r.bit_ready_flag)
        else $error("ready flag not cleared");

    a_arl_clear: assert property (flag_clr.arbitration_loss_flag && !flag_set.arbitration_loss_flag && clk_en
        |=> !flags_r.arbitration_loss_flag)
        else $error("arbitration flag not cleared");

    a_start_clear: assert property (flag_clr.str && !flag_set.str && clk_en
        |=> !flags_r.str)
        else $error("start flag not cleared");

    a_xmit_clear: assert property (con_wr && req.wdata[CON_CXA] && clk_en
        |=> !tx_act_r)
        else $error("transmit active not cleared");

    a_master_view: assert property (con_rd && clk_en |=>
        rdata[1] == $past(master_r))
        else $error("master bit does not match state");

    c_start_seen: cover property (flag_set.str);
    c_arb_lost:   cover property (flag_set.arbitration_loss_flag);
    c_buf_full:   cover property (buf_full && !rx_ready);
    c_stop_sent:  cover property (gen_done && gen_stop_r);

endmodule

// ### logic/i2c_bit_port_pkg.sv
// constants, types and register map of the bit-level i2c port
package i2c_bit_port_pkg;

    // clock and bus timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int SCL_HALF_NS   = 5000;
    localparam int SCL_HALF_CYC  = (SCL_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W         = 8;

    // register offsets and reset value
    localparam logic [7:0] OFF_CON   = 8'hD8;
    localparam logic [7:0] OFF_DAT   = 8'hD9;
    localparam logic [7:0] CON_RESET = 8'h81;

    // control/status bit positions (write meaning)
    localparam int CON_CXA  = 7;
    localparam int CON_IGN  = 6;
    localparam int CON_CDR  = 5;
    localparam int CON_CLEAR_ARBITRATION_LOSS = 4;
    localparam int CON_CLEAR_START_DETECTED = 3;
    localparam int CON_CLEAR_STOP_DETECTED = 2;
    localparam int CON_SEND_REPEATED_START = 1;
    localparam int CON_SEND_STOP = 0;
    // read meaning of bit 6
    localparam int CON_ATN  = 6;
    localparam int DAT_BIT  = 7;

    // the four sticky flags
    typedef struct packed {
        logic bit_ready_flag;
        logic arbitration_loss_flag;
        logic str;
        logic stop_detected_flag;
    } flags_t;

    // one register bus request
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    // start/stop generator, gray coded along its path
    typedef enum logic [1:0] {
        GEN_IDLE  = 2'b00,
        GEN_SETUP = 2'b01,
        GEN_SCLHI = 2'b11,
        GEN_EDGE  = 2'b10
    } gen_st_t;

endpackage

// ### test/i2c_far_end.sv
// far-side bus master model: start, single bits and stop on open-drain lines
`timescale 1ns/1ps
module i2c_far_end (
    // wire levels
    input  wire logic scl,
    input  wire logic sda,
    // pull-down enables of this party
    output logic      scl_oe,
    output logic      sda_oe
);
    localparam int HALF_NS = 200;

    // released lines float high on the pull-ups
    initial begin
        scl_oe = 1'b0;
        sda_oe = 1'b0;
    end

    // bounded wait so a stuck stretch cannot hang the model
    task automatic let_scl_rise();
        int i;
        scl_oe = 1'b0;
        for (i = 0; i < 4000 && !scl; i++) #10;
    endtask

    task automatic start();
        #13 sda_oe = 1'b1;
        #HALF_NS scl_oe = 1'b1;
        #HALF_NS;
    endtask

    // data moves only while scl is low
    task automatic send_bit(input logic b);
        #13 sda_oe = ~b;
        #HALF_NS let_scl_rise();
        #HALF_NS scl_oe = 1'b1;
        #HALF_NS;
    endtask

    task automatic stop();
        #13 sda_oe = 1'b1;
        #HALF_NS let_scl_rise();
        #HALF_NS sda_oe = 1'b0;
        #HALF_NS;
    endtask
endmodule

// ### test/testbench.sv
// self-checking bench for the bit-level i2c port
`timescale 1ns/1ps
module testbench;
    import i2c_bit_port_pkg::*;
    logic       ref_clk, resetn, clk_en, wr, rd, rx_ready, sda_q;
    logic [7:0] addr, wdata, rdata, rv;
    logic       scl_oe, sda_oe, p_scl_oe, p_sda_oe, rx_valid, scl_out, sda_out;
    logic [0:0] rx_bit;
    int         error_cnt, n_checks, n_st, n_sp;
    wire        scl = !(scl_oe | p_scl_oe);
    wire        sda = !(sda_oe | p_sda_oe);

    // short scl half period keeps the master run brief
    i2c_bit_level_port #(.HALF_CYC(8'h04)) i2c_bit_level_port_inst (
        .ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .scl_in(scl),
        .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_out),
        .sda_oe(sda_oe),
        .rx_valid(rx_valid), .rx_bit(rx_bit), .rx_ready(rx_ready));
    i2c_far_end i2c_far_end_inst (.scl(scl), .sda(sda), .scl_oe(p_scl_oe),
        .sda_oe(p_sda_oe));

    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    // count start and stop conditions seen on the wire
    always @(posedge ref_clk) begin
        sda_q <= sda;
        n_st  <= n_st + int'(scl && sda_q && !sda);
        n_sp  <= n_sp + int'(scl && !sda_q && sda);
    end

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t seen=%h expected=%h", $time, got, exp);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [7:0] a);
        @(posedge ref_clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1 rv = rdata;
    endtask

    task automatic pop(input logic b);
        check(rx_valid, 1'b1);
        check(rx_bit, b);
        @(posedge ref_clk);
        rx_ready <= 1'b1;
        @(posedge ref_clk);
        rx_ready <= 1'b0;
        #1;
    endtask

    task automatic complete_run();
        $display("checks=%0d mismatches=%0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic test_regs();
        rd_reg(OFF_CON);
        check(rv, CON_RESET);
        rd_reg(8'h00);
        check(rv, 8'h00);
        wr_reg(8'hDA, 8'hFF);
        rd_reg(OFF_CON);
        check(rv, CON_RESET);
        $display("done regs");
    endtask

    // strobes made while the enable is low are lost; a start request must not launch
    task automatic test_enable();
        @(posedge ref_clk);
        clk_en <= 1'b0;
        wr_reg(OFF_CON, 8'h02);
        rd_reg(OFF_CON);
        check(rv, 8'h00);
        check(scl_oe, 1'b0);
        @(posedge ref_clk);
        clk_en <= 1'b1;
        idle(3);
        check(scl_oe, 1'b0);
        rd_reg(OFF_CON);
        check(rv, CON_RESET);
        $display("done enable");
    endtask

    // start flag holds scl, then bits fill the stream buffer until it stalls
    task automatic test_rx();
        i2c_far_end_inst.start();
        idle(10);
        rd_reg(OFF_CON);
        check(rv, 8'hC9);
        wr_reg(OFF_CON, 8'h20);
        fork
            i2c_far_end_inst.send_bit(1'b0);
            begin
                idle(20);
                check(scl_oe, 1'b1);
                check(scl_out, 1'b0);
                wr_reg(OFF_CON, 8'h08);
            end
        join
        idle(5);
        rd_reg(OFF_CON); // attention first, then ready
        check(rv, 8'h61);
        rd_reg(OFF_DAT);
        check(rv, 8'h00);
        rd_reg(OFF_CON);
        check(rv, 8'h01);
        check(scl_oe, 1'b0);
        i2c_far_end_inst.send_bit(1'b1);
        idle(5);
        rd_reg(OFF_DAT);
        check(rv, 8'h80);
        fork
            i2c_far_end_inst.send_bit(1'b1);
            begin
                idle(20);
                check(scl_oe, 1'b1);
                pop(1'b0);
                pop(1'b1);
            end
        join
        idle(5);
        wr_reg(OFF_CON, 8'h20);
        rd_reg(OFF_CON);
        check(rv, 8'h81);
        pop(1'b1);
        check(rx_valid, 1'b0);
        $display("done rx");
    endtask

    // send a zero, then lose arbitration on a one, then a bus stop
    task automatic test_tx();
        wr_reg(OFF_DAT, 8'h00);
        idle(5);
        check(sda_oe, 1'b1);
        check(sda_out, 1'b0);
        i2c_far_end_inst.send_bit(1'b1);
        idle(5);
        rd_reg(OFF_CON);
        check(rv, 8'h61);
        pop(1'b0);
        wr_reg(OFF_DAT, 8'h80);
        idle(5);
        check(sda_oe, 1'b0);
        rd_reg(OFF_CON);
        check(rv, 8'h01);
        i2c_far_end_inst.send_bit(1'b0);
        idle(5);
        rd_reg(OFF_CON);
        check(rv, 8'h71);
        check(sda_oe, 1'b0);
        pop(1'b0);
        wr_reg(OFF_CON, 8'hB0);
        rd_reg(OFF_CON);
        check(rv, 8'h01);
        i2c_far_end_inst.stop();
        idle(5);
        rd_reg(OFF_CON);
        check(rv, 8'h65);
        pop(1'b0);
        wr_reg(OFF_CON, 8'h24);
        rd_reg(OFF_CON);
        check(rv, 8'h01);
        $display("done tx");
    endtask

    // own start and stop, stream drained meanwhile
    task automatic test_master();
        int s0;
        int p0;
        s0 = n_st;
        p0 = n_sp;
        @(posedge ref_clk);
        rx_ready <= 1'b1;
        wr_reg(OFF_CON, 8'h02);
        idle(40);
        rd_reg(OFF_CON);
        check(rv[1], 1'b1);
        check(8'(n_st > s0), 8'h01);
        wr_reg(OFF_CON, 8'h3C);
        wr_reg(OFF_CON, 8'h01);
        idle(60);
        rd_reg(OFF_CON);
        check(rv[1], 1'b0);
        check(8'(n_sp > p0), 8'h01);
        @(posedge ref_clk);
        rx_ready <= 1'b0;
        wr_reg(OFF_CON, 8'hBC);
        $display("done master");
    endtask

    task automatic test_ignore();
        wr_reg(OFF_CON, 8'h40);
        i2c_far_end_inst.start();
        idle(10);
        rd_reg(OFF_CON);
        check(rv[3], 1'b0);
        check(scl_oe, 1'b0);
        i2c_far_end_inst.stop();
        wr_reg(OFF_CON, 8'h3C);
        i2c_far_end_inst.start();
        idle(10);
        rd_reg(OFF_CON);
        check(rv[6:3], 4'h9);
        wr_reg(OFF_CON, 8'h3C);
        i2c_far_end_inst.stop();
        $display("done ignore");
    endtask

    // cuts a hang well past the expected run length
    initial begin
        #2000000;
        error_cnt++;
        complete_run();
    end

    initial begin
        resetn = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        clk_en = 1'b1;
        rx_ready = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
        sda_q = 1'b1;
        error_cnt = 0;
        n_checks = 0;
        n_st = 0;
        n_sp = 0;
        repeat (20) @(posedge ref_clk);
        resetn <= 1'b1;
        idle(3);
        test_regs();
        test_enable();
        test_rx();
        test_tx();
        test_master();
        test_ignore();
        complete_run();
    end
endmodule
